// *** include/lsac_pkg.sv ***
// Package for the log set-point and converter control block.
// Assumes one 125 MHz clock; register access by byte address and strobes.
package lsac_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CODE_W = 10;
  localparam int SEL_W  = 3;

  localparam logic [5:0] ADDR_RESULT_HIGH  = 6'h03;
  localparam logic [5:0] ADDR_RESULT_LOW   = 6'h04;
  localparam logic [5:0] ADDR_CONV_CTRL    = 6'h10;
  localparam logic [5:0] ADDR_RES_CODE     = 6'h12;
  localparam logic [5:0] ADDR_SETPT_HIGH   = 6'h13;
  localparam logic [5:0] ADDR_SETPT_LOW    = 6'h14;

  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  localparam int SEL_LSB     = 5;
  localparam int SEL_MSB     = 7;
  localparam int DIS_BIT     = 2;
  localparam int HIGH_MSB    = 1;

  localparam logic [7:0] RES_CODE_RST  = 8'hff;
  localparam logic [9:0] SETPT_RST     = 10'h000;
  localparam logic [2:0] SEL_RST       = 3'h0;
  localparam logic       DIS_RST       = 1'b0;

  localparam int CLK_HZ      = 125000000;
  localparam int CONV_US     = 140;
  localparam int SETTLE_US   = 500;
  localparam int CONV_CYC    = CONV_US * (CLK_HZ / 1000000);
  localparam int SETTLE_CYC  = SETTLE_US * (CLK_HZ / 1000000);

  typedef enum logic [2:0] {
    SRC_LOGIC_SUPPLY,
    SRC_LASER_SUPPLY,
    SRC_MAIN_SUPPLY,
    SRC_MONITOR_SENSE,
    SRC_SHUNT_SENSE,
    SRC_NEG_DRIVE,
    SRC_POS_DRIVE,
    SRC_AUX_PIN
  } lsac_src_t;
endpackage

// *** include/lsac_conv_if.sv ***
// Carrier between the top and the conversion sequencer.
// Assumes both ends share the top's clock.
`timescale 1ns/1ps
interface lsac_conv_if;
  logic [2:0] source_select;
  logic       sel_changed;
  logic       sample_valid;
  logic [9:0] sample_data;
  logic       start_conv;
  logic       result_load;
  logic [9:0] result_data;
  modport ctrl (input source_select, sel_changed, sample_valid, sample_data,
                output start_conv, result_load, result_data);
  modport top  (output source_select, sel_changed, sample_valid, sample_data,
                input start_conv, result_load, result_data);
endinterface

// *** rtl/lsac_timer.sv ***
// Down counter that pulses done when a loaded count runs out.
// Assumes load wins over a running count.
`timescale 1ns/1ps
module lsac_timer #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  output logic                  busy,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_r;
  logic             busy_r;
  logic             done_r;
  wire  last_w = busy_r && (cnt_r == CNT_W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= last_w && !load;
      if (load) begin
        cnt_r  <= count;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        cnt_r  <= cnt_r - CNT_W'(1);
        busy_r <= !last_w;
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule

// *** rtl/lsac_conv_seq.sv ***
// Continuous conversion sequencer with settling hold-off.
// Assumes the converter front end holds sample_data valid when each conversion count ends; sample_valid is not used.
`timescale 1ns/1ps
module lsac_conv_seq #(
  parameter int CONV_CYCLES   = lsac_pkg::CONV_CYC,
  parameter int SETTLE_CYCLES = lsac_pkg::SETTLE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  lsac_conv_if.ctrl cif
);
  localparam int CW = $clog2(SETTLE_CYCLES + CONV_CYCLES + 1);
  typedef enum logic [1:0] {ST_IDLE, ST_CONV} lsac_cst_t;
  lsac_cst_t  st_r;
  logic       start_r;
  logic       load_r;
  logic [9:0] res_r;
  logic       conv_busy;
  logic       conv_done;
  logic       settle_busy;

  // Settling window restarts on each select change
  lsac_timer #(.CNT_W(CW)) u_settle (
    .clk(clk), .rst_n(rst_n), .load(cif.sel_changed),
    .count(CW'(SETTLE_CYCLES)), .busy(settle_busy), .done());

  lsac_timer #(.CNT_W(CW)) u_conv (
    .clk(clk), .rst_n(rst_n), .load(start_r),
    .count(CW'(CONV_CYCLES)), .busy(conv_busy), .done(conv_done));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= ST_IDLE;
      start_r <= 1'b0;
      load_r  <= 1'b0;
      res_r   <= '0;
    end else begin
      start_r <= 1'b0;
      load_r  <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          start_r <= 1'b1; // [R12]
          st_r    <= ST_CONV;
        end
        ST_CONV: begin
          if (conv_done) begin // [R13]
            // Results during settling are dropped, old value stays [R19]
            if (!settle_busy && !cif.sel_changed) begin // [R14]
              load_r <= 1'b1;
              res_r  <= cif.sample_data;
            end
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign cif.start_conv  = start_r;
  assign cif.result_load = load_r;
  assign cif.result_data = res_r;
endmodule

// *** rtl/lsac_top.sv ***
// Register file and analog control outputs of the log set-point block.
// Assumes a decoded serial byte port: opcode, address, write data and one strobe.
`timescale 1ns/1ps

// Overview of operation
// [R1] Resistor code drives monotonic log resistor select
// [R2] Code 0xFF is maximum; reset value 0xFF
// [R3] Control bit 2 disables internal resistor
// [R4] Current mode drops resistor from loop only
// [R5] Software sets disable for external resistor
// [R6] Set-point code split over two registers
// [R7] Set-point maps monotonically onto reference level
// [R8] Reference converter follows code in all modes
// [R9] Software power-mode calibration procedure
// [R10] Software current-mode calibration procedure
// [R11] Three-bit source select routes converter input
// [R12] Converter runs continuously without trigger
// [R13] Each conversion takes 140 microseconds
// [R14] Source change needs 500 microseconds settling
// [R15] No end flag; last valid result shown
// [R16] Result is read-only, split over two registers
// [R17] Software reads result halves back to back
// [R18] Serial opcode: 10 read, 01 write
// [R19] Old result kept until settled conversion
// [R20] Intervals timed by counted clock cycles
module lsac_top #(
  parameter int CONV_CYCLES   = lsac_pkg::CONV_CYC,
  parameter int SETTLE_CYCLES = lsac_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // Register port from serial decoder
  input  wire logic [1:0] REG_OPCODE,
  input  wire logic [5:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_STROBE,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  // Operating mode
  input  wire logic       CURRENT_CONTROL_LOOP,
  // Converter front end
  input  wire logic       SAMPLE_VALID,
  input  wire logic [9:0] SAMPLE_DATA,
  output logic            CONV_START,
  output logic      [2:0] CONV_SOURCE,
  // Analog helpers
  output logic      [7:0] LOG_MONITOR_RESISTOR,
  output logic            RESISTOR_ENABLE,
  output logic            RESISTOR_IN_LOOP,
  output logic      [9:0] SETPOINT_CODE
);
  lsac_conv_if cif ();

  logic [7:0] res_code_r;
  logic [7:0] res_code_nxt;
  logic       dis_r;
  logic       dis_nxt;
  logic [2:0] sel_r;
  logic [2:0] sel_nxt;
  logic [9:0] setpt_r;
  logic [9:0] setpt_nxt;
  logic [9:0] result_r;
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic       start_o_r;
  logic [2:0] src_o_r;
  logic [7:0] res_o_r;
  logic       en_o_r;
  logic       loop_o_r;
  logic [9:0] setpt_o_r;
  logic       sel_chg_r;

  // Serial access decode
  wire wr_w = REG_STROBE && (REG_OPCODE == lsac_pkg::OP_WRITE); // [R18]
  wire rd_w = REG_STROBE && (REG_OPCODE == lsac_pkg::OP_READ); // [R18]
  wire wr_ctrl_w  = wr_w && (REG_ADDR == lsac_pkg::ADDR_CONV_CTRL);
  wire wr_res_w   = wr_w && (REG_ADDR == lsac_pkg::ADDR_RES_CODE);
  wire wr_sph_w   = wr_w && (REG_ADDR == lsac_pkg::ADDR_SETPT_HIGH);
  wire wr_spl_w   = wr_w && (REG_ADDR == lsac_pkg::ADDR_SETPT_LOW);
  wire [2:0] wsel_w = REG_WDATA[lsac_pkg::SEL_MSB:lsac_pkg::SEL_LSB];

  function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [9:0] res,
                                          input logic [2:0] sel, input logic dis,
                                          input logic [7:0] rc, input logic [9:0] sp);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      lsac_pkg::ADDR_RESULT_HIGH: v = {6'h00, res[9:8]};
      lsac_pkg::ADDR_RESULT_LOW:  v = res[7:0];
      lsac_pkg::ADDR_CONV_CTRL:   v = {sel, 2'h0, dis, 2'h0};
      lsac_pkg::ADDR_RES_CODE:    v = rc;
      lsac_pkg::ADDR_SETPT_HIGH:  v = {6'h00, sp[9:8]};
      lsac_pkg::ADDR_SETPT_LOW:   v = sp[7:0];
      default:                    v = 8'h00;
    endcase
    return v;
  endfunction

  assign res_code_nxt = wr_res_w ? REG_WDATA : res_code_r; // [R1]
  assign dis_nxt      = wr_ctrl_w ? REG_WDATA[lsac_pkg::DIS_BIT] : dis_r; // [R3]
  assign sel_nxt      = wr_ctrl_w ? wsel_w : sel_r; // [R11]
  assign setpt_nxt    = {wr_sph_w ? REG_WDATA[lsac_pkg::HIGH_MSB:0] : setpt_r[9:8],
                         wr_spl_w ? REG_WDATA : setpt_r[7:0]}; // [R6]

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      res_code_r <= lsac_pkg::RES_CODE_RST; // [R2]
      dis_r      <= lsac_pkg::DIS_RST;
      sel_r      <= lsac_pkg::SEL_RST;
      setpt_r    <= lsac_pkg::SETPT_RST;
      sel_chg_r  <= 1'b0;
    end else begin
      res_code_r <= res_code_nxt;
      dis_r      <= dis_nxt;
      sel_r      <= sel_nxt;
      setpt_r    <= setpt_nxt;
      sel_chg_r  <= wr_ctrl_w && (wsel_w != sel_r); // [R14]
    end
  end

  // Result store; no write path reaches it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      result_r <= '0;
    end else if (cif.result_load) begin
      result_r <= cif.result_data; // [R15]
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd_w;
      if (rd_w) begin
        rdata_r <= read_mux(REG_ADDR, result_r, sel_r, dis_r, res_code_r, setpt_r); // [R16]
      end
    end
  end

  // Registered analog controls; mode never gates the reference
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      start_o_r <= 1'b0;
      src_o_r   <= lsac_pkg::SEL_RST;
      res_o_r   <= lsac_pkg::RES_CODE_RST;
      en_o_r    <= 1'b1;
      loop_o_r  <= 1'b0;
      setpt_o_r <= lsac_pkg::SETPT_RST;
    end else begin
      start_o_r <= cif.start_conv; // [R12]
      src_o_r   <= sel_r; // [R11]
      res_o_r   <= res_code_r; // [R1]
      en_o_r    <= !dis_r; // [R3]
      loop_o_r  <= !dis_r && !CURRENT_CONTROL_LOOP; // [R4]
      setpt_o_r <= setpt_r; // [R7] [R8]
    end
  end

  assign cif.source_select = sel_r;
  assign cif.sel_changed   = sel_chg_r;
  assign cif.sample_valid  = SAMPLE_VALID;
  assign cif.sample_data   = SAMPLE_DATA;

  // Cycle-counted intervals
  lsac_conv_seq #(
    .CONV_CYCLES(CONV_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_seq (
    .clk(CLK),
    .rst_n(RSTN),
    .cif(cif)
  ); // [R20] [R13]

  assign REG_RDATA            = rdata_r;
  assign REG_RVALID           = rvalid_r;
  assign CONV_START           = start_o_r;
  assign CONV_SOURCE          = src_o_r;
  assign LOG_MONITOR_RESISTOR = res_o_r;
  assign RESISTOR_ENABLE      = en_o_r;
  assign RESISTOR_IN_LOOP     = loop_o_r;
  assign SETPOINT_CODE        = setpt_o_r;
endmodule

// *** verif/lsac_assertions.sv ***
// Port checker for the log set-point and converter control top.
// Assumes it is bound to lsac_top and sees only its ports.
`timescale 1ns/1ps
module lsac_assertions #(
  parameter int CONV_CYCLES = 20
) (
  // Clock, reset and register port
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic [1:0] REG_OPCODE,
  input wire logic       REG_STROBE,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  // Mode, converter and analog outputs
  input wire logic       CURRENT_CONTROL_LOOP,
  input wire logic       CONV_START,
  input wire logic [2:0] CONV_SOURCE,
  input wire logic [7:0] LOG_MONITOR_RESISTOR,
  input wire logic       RESISTOR_ENABLE,
  input wire logic       RESISTOR_IN_LOOP,
  input wire logic [9:0] SETPOINT_CODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  int   gap_r;
  logic rd;
  assign rd = REG_STROBE && REG_OPCODE == 2'h2;
  // Zero until the first start, so the first period is not judged
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) gap_r <= 0;
    else if (CONV_START) gap_r <= 1;
    else if (gap_r != 0) gap_r <= gap_r + 1;
  end
  property p_read_answer; rd |=> REG_RVALID; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_spurious; !rd |=> !REG_RVALID; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("stray read valid");
  property p_rdata_hold; !rd |=> $stable(REG_RDATA); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_loop_mode; $past(CURRENT_CONTROL_LOOP) |-> !RESISTOR_IN_LOOP; endproperty
  a_loop_mode: assert property (p_loop_mode) else $error("resistor in loop");
  property p_loop_disabled; !RESISTOR_ENABLE [*2] |-> !RESISTOR_IN_LOOP; endproperty
  a_loop_disabled: assert property (p_loop_disabled) else $error("disabled in loop");
  property p_out_quiet;
    !REG_STROBE [*4] |-> $stable({SETPOINT_CODE, LOG_MONITOR_RESISTOR, CONV_SOURCE,
                                   RESISTOR_ENABLE});
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output moved");
  property p_start_pulse; CONV_START |=> !CONV_START; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_period; CONV_START && gap_r != 0 |-> gap_r == CONV_CYCLES + 3; endproperty
  a_start_period: assert property (p_start_period) else $error("bad period");
  property p_no_stall; gap_r <= CONV_CYCLES + 3; endproperty
  a_no_stall: assert property (p_no_stall) else $error("conversion stalled");
  cover property (rd);
  cover property (CONV_START && gap_r != 0);
  cover property (CURRENT_CONTROL_LOOP && !RESISTOR_IN_LOOP);
endmodule

bind lsac_top lsac_assertions #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
  .CLK(CLK), .RSTN(RSTN), .REG_OPCODE(REG_OPCODE), .REG_STROBE(REG_STROBE),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CURRENT_CONTROL_LOOP(CURRENT_CONTROL_LOOP),
  .CONV_START(CONV_START), .CONV_SOURCE(CONV_SOURCE), .LOG_MONITOR_RESISTOR(LOG_MONITOR_RESISTOR),
  .RESISTOR_ENABLE(RESISTOR_ENABLE), .RESISTOR_IN_LOOP(RESISTOR_IN_LOOP),
  .SETPOINT_CODE(SETPOINT_CODE));

// *** verif/log_setpoint_and_adc_control_tb.sv ***
// Self-checking bench for the log set-point and converter control block.
// Assumes short conversion and settling counts to keep the run brief.
`timescale 1ns/1ps
module log_setpoint_and_adc_control_tb;
  localparam int CONV = 20;
  localparam int SETTLE = 50;
  logic       clk, rstn, strobe, ccl, svalid, rvalid, cstart, r_en, r_loop;
  logic [1:0] op;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, rcode;
  logic [9:0] sdata, setpt;
  logic [2:0] src;
  int         mismatches, checked;

  lsac_top #(.CONV_CYCLES(CONV), .SETTLE_CYCLES(SETTLE)) dut_u (
    .CLK(clk), .RSTN(rstn), .REG_OPCODE(op), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_STROBE(strobe), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .CURRENT_CONTROL_LOOP(ccl), .SAMPLE_VALID(svalid), .SAMPLE_DATA(sdata),
    .CONV_START(cstart), .CONV_SOURCE(src), .LOG_MONITOR_RESISTOR(rcode),
    .RESISTOR_ENABLE(r_en), .RESISTOR_IN_LOOP(r_loop), .SETPOINT_CODE(setpt));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [1:0] o, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    op = o;
    addr = a;
    wdata = d;
    strobe = 1'b1;
    @(posedge clk);
    #1;
    strobe = 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(lsac_pkg::OP_WRITE, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    acc(lsac_pkg::OP_READ, a, 8'h00);
    chk({1'b0, rvalid, rdata}, {2'h1, exp});
  endtask

  task automatic t_reset;
    rd(lsac_pkg::ADDR_RES_CODE, 8'hff);
    rd(lsac_pkg::ADDR_CONV_CTRL, 8'h00);
    rd(lsac_pkg::ADDR_SETPT_HIGH, 8'h00);
    rd(lsac_pkg::ADDR_SETPT_LOW, 8'h00);
    chk({r_en, 1'b0, rcode}, 10'h2ff);
    chk(setpt, 10'h000);
    $display("reset test done");
  endtask

  task automatic t_regs;
    wr(lsac_pkg::ADDR_RES_CODE, 8'h00);
    wr(lsac_pkg::ADDR_SETPT_HIGH, 8'h03);
    wr(lsac_pkg::ADDR_SETPT_LOW, 8'hff);
    wr(lsac_pkg::ADDR_CONV_CTRL, 8'h84);
    // Undefined opcode and read-only or unmapped targets must change nothing
    acc(2'h3, lsac_pkg::ADDR_RES_CODE, 8'h55);
    wr(lsac_pkg::ADDR_RESULT_HIGH, 8'hff);
    wr(6'h3f, 8'hff);
    rd(lsac_pkg::ADDR_RES_CODE, 8'h00);
    rd(lsac_pkg::ADDR_SETPT_HIGH, 8'h03);
    rd(lsac_pkg::ADDR_SETPT_LOW, 8'hff);
    rd(lsac_pkg::ADDR_CONV_CTRL, 8'h84);
    rd(lsac_pkg::ADDR_RESULT_HIGH, 8'h00);
    rd(6'h3f, 8'h00);
    chk({rcode, r_en, r_loop}, 10'h000);
    chk(setpt, 10'h3ff);
    chk({7'h00, src}, 10'h004);
    $display("register test done");
  endtask

  task automatic t_modes;
    wr(lsac_pkg::ADDR_CONV_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk({r_en, r_loop}, 10'h003);
    ccl = 1'b1;
    wr(lsac_pkg::ADDR_SETPT_LOW, 8'h5a);
    repeat (3) @(posedge clk);
    #1;
    chk({r_en, r_loop}, 10'h002);
    chk(setpt, 10'h35a);
    ccl = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(lsac_pkg::ADDR_CONV_CTRL, {i[2:0], 5'h00});
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, src}, {7'h00, i[2:0]});
    end
    $display("mode test done");
  endtask

  task automatic t_calib;
    // Power-mode bring-up: high resistor code, mid set-point, then trim
    wr(lsac_pkg::ADDR_RES_CODE, 8'hf0);
    wr(lsac_pkg::ADDR_SETPT_HIGH, 8'h02);
    wr(lsac_pkg::ADDR_SETPT_LOW, 8'h00);
    wr(lsac_pkg::ADDR_RES_CODE, 8'h80);
    wr(lsac_pkg::ADDR_SETPT_LOW, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    chk({2'h0, rcode}, 10'h080);
    chk(setpt, 10'h210);
    // Current-mode bring-up: set-point 0xff, then step down
    ccl = 1'b1;
    wr(lsac_pkg::ADDR_SETPT_HIGH, 8'h00);
    wr(lsac_pkg::ADDR_SETPT_LOW, 8'hff);
    wr(lsac_pkg::ADDR_SETPT_LOW, 8'hc0);
    repeat (2) @(posedge clk);
    #1;
    chk(setpt, 10'h0c0);
    ccl = 1'b0;
    $display("calibration test done");
  endtask

  task automatic t_conv;
    sdata = 10'h2a5;
    repeat (SETTLE + 3 * (CONV + 3)) @(posedge clk);
    rd(lsac_pkg::ADDR_RESULT_HIGH, 8'h02);
    rd(lsac_pkg::ADDR_RESULT_LOW, 8'ha5);
    wr(lsac_pkg::ADDR_CONV_CTRL, 8'h20);
    sdata = 10'h15a;
    repeat (SETTLE - 10) @(posedge clk);
    rd(lsac_pkg::ADDR_RESULT_HIGH, 8'h02);
    rd(lsac_pkg::ADDR_RESULT_LOW, 8'ha5);
    repeat (SETTLE + 3 * (CONV + 3)) @(posedge clk);
    rd(lsac_pkg::ADDR_RESULT_HIGH, 8'h01);
    rd(lsac_pkg::ADDR_RESULT_LOW, 8'h5a);
    $display("conversion test done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #50000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    strobe = 1'b0;
    op = 2'h0;
    addr = 6'h00;
    wdata = 8'h00;
    ccl = 1'b0;
    svalid = 1'b0;
    sdata = 10'h000;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_calib();
    t_conv();
    end_of_test();
  end
endmodule
